// *** buck_fault_supervisor.sv ***
// fault supervision and power good sequencing for a step-down converter
`timescale 1ns/10ps
`include "buck_fault_supervisor_regs.svh"
// overview:
// the sequencer walks idle, soft-start, run, thermal hold and undervoltage
// latch-off; each fault latch sits beside it in a process of its own
// the driver controls are built from the next values of the overvoltage
// latch and the sinking flag, so a trip takes the high side off in the
// same edge that raises its status flag
// all comparator flags are levels taken as synchronous to clk; the analog
// side is expected to filter them before they get here
// delays are counted in clk cycles; the defaults assume a 100 MHz clock
// and the undervoltage and power good delays can be shortened through the parameters for quick runs
// enable low behaves like reset for every latch, so a tripped converter
// is re-armed by pulling enable low and raising it again
// the thermal hold is not a latch: the ramp restarts by itself once the
// die has cooled
// the undervoltage latch-off is left only through enable or reset
// hazard: comparator chatter near a threshold restarts the delay counts
module buck_fault_supervisor #(
   parameter int unsigned UV_DELAY = `UV_DELAY_CYC,
   parameter int unsigned PG_DELAY = `PG_DELAY_CYC
) (
   // clock and synchronous reset
   input wire logic clk,
   input wire logic sys_rst,
   // enable pin and comparator levels, all synchronous to clk
   input wire logic enable_in,
   input wire buck_fault_supervisor_pkg::feedback_sense_s feedback_sense,
   input wire logic over_temp,
   input wire logic temp_recovered,
   input wire logic soft_start_done,
   input wire logic neg_limit_hit,
   input wire logic switch_cycle,
   input wire logic [2:0] mode_strap,
   // status flags and driver controls, each straight from a flip-flop
   output logic soft_start_run,
   output logic ref_discharge,
   output buck_fault_supervisor_pkg::drive_s drive,
   output logic neg_limit_active,
   output logic power_good_output,
   output logic undervoltage_trip,
   output logic overvoltage_trip,
   output logic output_sink_operation,
   output logic thermal_shutdown,
   // decoded strap setting
   output buck_fault_supervisor_pkg::light_load_e light_mode,
   output buck_fault_supervisor_pkg::freq_e freq_sel
);
   localparam int unsigned NEG_OFF = `NEG_OFF_CYC;
   typedef enum logic [2:0] {S_IDLE, S_SOFT, S_RUN, S_THERM, S_UV_OFF} seq_e;
   // sequencer state, counters and latches
   seq_e state_q;                // sequencer state
   logic en_q;                   // previous enable for edge
   logic [31:0] uv_cnt_q;        // undervoltage delay counter
   logic [31:0] pg_cnt_q;        // power good delay counter
   logic pg_latched_q;           // power good held low
   logic [7:0] off_cnt_q;        // low side off timer
   logic [3:0] sink_cnt_q;       // forced cycles in sinking
   logic armed;                  // soft-start complete and running
   logic clear_all;              // enable low or reset
   logic fb_fault;               // power good window broken
   // next values, shared between the latches and the driver controls
   logic ov_d;                   // next overvoltage latch
   logic sink_d;                 // next output sinking flag
   logic [3:0] sink_cnt_d;       // next forced cycle count

   // undervoltage and power good only count in the run state;
   // enable low acts like reset on every latch
   assign armed = (state_q == S_RUN);
   assign clear_all = sys_rst || !enable_in;
   assign fb_fault = feedback_sense.below_80 || feedback_sense.above_116;

   // sequencer: idle, soft-start, run, thermal hold, uv latched
   // en_q keeps the last enable level so that idle only leaves on a fresh
   // rising enable or on over_temp; the enable edge re-arms a tripped converter
   always_ff @(posedge clk) begin
      en_q <= enable_in;
      // enable low or reset wins over every other cause
      if (clear_all) begin
         state_q <= S_IDLE;
      end else if (over_temp && state_q != S_UV_OFF) begin
         // die too hot: hold off from any state but the latch-off
         state_q <= S_THERM;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               // leave only on a fresh rising enable
               if (!en_q) begin
                  state_q <= S_SOFT; // fresh enable edge
               end
            end
            S_SOFT: begin
               // the finished ramp arms the supervisors
               if (soft_start_done) begin
                  state_q <= S_RUN;
               end
            end
            S_RUN: begin
               // latch off once the delay ran out with the output still low
               if (uv_cnt_q >= UV_DELAY - 1 && feedback_sense.below_80) begin
                  state_q <= S_UV_OFF;
               end
            end
            S_THERM: begin
               // cooled down: restart through a new ramp
               if (temp_recovered) begin
                  state_q <= S_SOFT;
               end
            end
            S_UV_OFF: begin
               // no way out but enable low or reset
               state_q <= S_UV_OFF; // held until enable or reset
            end
         endcase
      end
   end

   // undervoltage delay counter
   // cleared whenever the output is back above the threshold, so a short dip
   // never latches; saturates at the end so the compare stays true
   always_ff @(posedge clk) begin
      if (clear_all || !armed || !feedback_sense.below_80) begin
         uv_cnt_q <= 32'h0;
      end else if (uv_cnt_q < UV_DELAY - 1) begin
         // still low: keep counting
         uv_cnt_q <= uv_cnt_q + 32'h1;
      end
   end

   // next value of the overvoltage latch; the drivers use it too, so the
   // high side drops in the same edge that raises the trip flag
   always_comb begin
      ov_d = overvoltage_trip;
      if (clear_all) begin
         ov_d = 1'b0;
      end else if (feedback_sense.above_116 && state_q != S_IDLE) begin
         ov_d = 1'b1;
      end
   end

   // overvoltage latch: set by the comparator, held until enable or reset
   always_ff @(posedge clk) begin
      overvoltage_trip <= ov_d;
   end

   // next value of the non-latching output sinking and its cycle count;
   // sinking may start again at once if the output is still high after
   // the fifteen forced cycles, which keeps pulling it down
   always_comb begin
      sink_d = output_sink_operation;
      sink_cnt_d = sink_cnt_q;
      if (clear_all || ov_d || state_q != S_RUN) begin
         // only in regulation, and the overvoltage sink takes over
         sink_d = 1'b0;
         sink_cnt_d = 4'h0;
      end else if (!output_sink_operation) begin
         // start on the small overshoot, no fault raised
         sink_d = feedback_sense.above_104;
         sink_cnt_d = 4'h0;
      end else if (!feedback_sense.above_102) begin
         // output back near the setpoint
         sink_d = 1'b0;
      end else if (switch_cycle) begin
         // one more forced continuous cycle
         if (sink_cnt_q == 4'(`SINK_CYCLES - 1)) begin
            sink_d = 1'b0;
         end
         sink_cnt_d = sink_cnt_q + 4'h1;
      end
   end

   // output sinking flag and its cycle counter
   always_ff @(posedge clk) begin
      output_sink_operation <= sink_d;
      sink_cnt_q <= sink_cnt_d;
   end

   // low side off timer after negative current limit
   // a trip while the timer runs is ignored; the low side stays off for the
   // whole interval and the comparator is looked at again afterwards
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         off_cnt_q <= 8'h0;
      end else if (neg_limit_active && neg_limit_hit && off_cnt_q == 8'h0) begin
         // limit tripped: start the fixed off interval
         off_cnt_q <= 8'(NEG_OFF);
      end else if (off_cnt_q != 8'h0) begin
         // count the interval down to zero
         off_cnt_q <= off_cnt_q - 8'h1;
      end
   end

   // driver outputs and status flags
   // the status flags follow the sequencer state one edge later; the driver
   // controls follow the next fault values so a trip and its driver action
   // show in the same cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // everything off, reference held discharged
         drive <= '0;
         neg_limit_active <= 1'b0;
         undervoltage_trip <= 1'b0;
         thermal_shutdown <= 1'b0;
         soft_start_run <= 1'b0;
         ref_discharge <= 1'b1;
      end else begin
         // status flags straight from the sequencer state
         undervoltage_trip <= (state_q == S_UV_OFF);
         thermal_shutdown <= (state_q == S_THERM);
         soft_start_run <= (state_q == S_SOFT);
         ref_discharge <= (state_q == S_THERM) || (state_q == S_IDLE);
         if (ov_d) begin
            // overvoltage: high side latched off, low side sinks in bursts
            // until the output is below half the setpoint
            drive.high_side_en <= 1'b0;
            drive.pwm_en <= 1'b0;
            drive.low_side_force <= !feedback_sense.below_50 && off_cnt_q == 8'h0;
            neg_limit_active <= !feedback_sense.below_50;
         end else if (sink_d) begin
            // output sinking: low side only, limit watched all the time
            drive.high_side_en <= 1'b0;
            drive.pwm_en <= 1'b0;
            drive.low_side_force <= (off_cnt_q == 8'h0);
            neg_limit_active <= 1'b1;
         end else begin
            // normal switching during ramp and run, off otherwise
            drive.high_side_en <= (state_q == S_SOFT) || (state_q == S_RUN);
            drive.pwm_en <= (state_q == S_SOFT) || (state_q == S_RUN);
            drive.low_side_force <= 1'b0;
            neg_limit_active <= 1'b0;
         end
      end
   end

   // power good delay and latch
   // the latch is set by any window fault once armed and by an overvoltage;
   // a new soft-start clears it, and a set in the same cycle wins
   always_ff @(posedge clk) begin
      if (clear_all) begin
         // enable low or reset clears the latch
         pg_latched_q <= 1'b0;
         pg_cnt_q <= 32'h0;
         power_good_output <= 1'b0;
      end else begin
         if (overvoltage_trip || (armed && fb_fault)) begin
            // fault wins over the soft-start clear
            pg_latched_q <= 1'b1;
         end else if (state_q == S_SOFT) begin
            // a new ramp gives power good another chance
            pg_latched_q <= 1'b0;
         end
         // count only while armed, unlatched and inside the window
         if (!armed || pg_latched_q || fb_fault || !feedback_sense.in_window) begin
            pg_cnt_q <= 32'h0;
            power_good_output <= 1'b0;
         end else if (pg_cnt_q < PG_DELAY - 1) begin
            // still counting the power good delay
            pg_cnt_q <= pg_cnt_q + 32'h1;
         end else begin
            // delay ran out inside the window
            power_good_output <= 1'b1;
         end
      end
   end

   // strap decode of light-load mode and frequency
   // unused codes fall back to the first setting; the decode is redone
   // every cycle so a strap change shows one edge later
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         light_mode <= buck_fault_supervisor_pkg::LL_PULSE_SKIP;
         freq_sel <= buck_fault_supervisor_pkg::FREQ_600K;
      end else begin
         case (mode_strap)
            `STRAP_R243K: begin
               light_mode <= buck_fault_supervisor_pkg::LL_PULSE_SKIP;
               freq_sel <= buck_fault_supervisor_pkg::FREQ_800K;
            end
            `STRAP_R121K: begin
               light_mode <= buck_fault_supervisor_pkg::LL_PULSE_SKIP;
               freq_sel <= buck_fault_supervisor_pkg::FREQ_1M;
            end
            `STRAP_GND: begin
               light_mode <= buck_fault_supervisor_pkg::LL_CONTINUOUS;
               freq_sel <= buck_fault_supervisor_pkg::FREQ_600K;
            end
            `STRAP_R30K: begin
               light_mode <= buck_fault_supervisor_pkg::LL_CONTINUOUS;
               freq_sel <= buck_fault_supervisor_pkg::FREQ_800K;
            end
            `STRAP_R60K: begin
               light_mode <= buck_fault_supervisor_pkg::LL_CONTINUOUS;
               freq_sel <= buck_fault_supervisor_pkg::FREQ_1M;
            end
            // unused codes: first setting
            default: begin
               light_mode <= buck_fault_supervisor_pkg::LL_PULSE_SKIP;
               freq_sel <= buck_fault_supervisor_pkg::FREQ_600K;
            end
         endcase
      end
   end
endmodule // buck_fault_supervisor

// *** buck_fault_supervisor_regs.svh ***
// constants for the buck fault supervisor: timing counts and strap codes
`ifndef BUCK_FAULT_SUPERVISOR_REGS_SVH
`define BUCK_FAULT_SUPERVISOR_REGS_SVH
`define CLK_MHZ 100
`define UV_DELAY_US 1000
`define UV_DELAY_CYC (`UV_DELAY_US * `CLK_MHZ)
`define PG_DELAY_US 800
`define PG_DELAY_CYC (`PG_DELAY_US * `CLK_MHZ)
`define NEG_OFF_NS 200
`define NEG_OFF_CYC ((`NEG_OFF_NS * `CLK_MHZ) / 1000)
`define SINK_CYCLES 15
`define STRAP_VCC 3'h0
`define STRAP_R243K 3'h1
`define STRAP_R121K 3'h2
`define STRAP_GND 3'h3
`define STRAP_R30K 3'h4
`define STRAP_R60K 3'h5
`endif

// *** buck_fault_supervisor_pkg.sv ***
// types for the buck fault supervisor
package buck_fault_supervisor_pkg;
   typedef enum logic [1:0] {FREQ_600K, FREQ_800K, FREQ_1M} freq_e;
   typedef enum logic {LL_PULSE_SKIP, LL_CONTINUOUS} light_load_e;
   // comparator flags from the feedback sensor
   typedef struct packed {
      logic below_50;
      logic below_80;
      logic in_window;
      logic above_102;
      logic above_104;
      logic above_116;
   } feedback_sense_s;
   // driver controls
   typedef struct packed {
      logic high_side_en;
      logic low_side_force;
      logic pwm_en;
   } drive_s;
endpackage

// *** buck_fault_supervisor_chk.sv ***
// checker holding the timing assertions of the fault supervisor
`timescale 1ns/10ps
module buck_fault_supervisor_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic neg_limit_hit,
   input wire logic [2:0] mode_strap,
   input wire logic soft_start_run,
   input wire logic ref_discharge,
   input wire buck_fault_supervisor_pkg::drive_s drive,
   input wire logic neg_limit_active,
   input wire logic power_good_output,
   input wire logic undervoltage_trip,
   input wire logic overvoltage_trip,
   input wire logic output_sink_operation,
   input wire logic thermal_shutdown,
   input wire buck_fault_supervisor_pkg::light_load_e light_mode,
   input wire buck_fault_supervisor_pkg::freq_e freq_sel
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // low side rests after a limit trip
   sequence ls_rest; !drive.low_side_force [*8]; endsequence
   // a fresh limit trip while sinking
   sequence trip_seen;
      $rose(neg_limit_hit) && (output_sink_operation || overvoltage_trip) && drive.low_side_force;
   endsequence
   AST_UV_OFF: assert property (undervoltage_trip |-> !drive.high_side_en && !drive.low_side_force)
      else $error("drivers on while undervoltage latched");
   AST_UV_SOFT: assert property (soft_start_run |-> !undervoltage_trip)
      else $error("undervoltage latched during soft start");
   AST_OV_HS: assert property (overvoltage_trip |-> !drive.high_side_en)
      else $error("high side on during overvoltage");
   AST_NEG_OFF: assert property (trip_seen |-> ##2 ls_rest)
      else $error("low side not rested after limit trip");
   AST_PG_SOFT: assert property (soft_start_run && $past(soft_start_run) |-> !power_good_output)
      else $error("power good during soft start");
   AST_PG_OV: assert property (overvoltage_trip && $past(overvoltage_trip) |-> !power_good_output)
      else $error("power good high after overvoltage");
   AST_THERM: assert property ($rose(thermal_shutdown) |-> ref_discharge && !drive.high_side_en)
      else $error("thermal shutdown left converter on");
   AST_SINK_LS: assert property ($rose(output_sink_operation) |-> !drive.high_side_en)
      else $error("high side on while sinking");
   AST_SINK_LIM: assert property (output_sink_operation |-> neg_limit_active)
      else $error("negative limit off while sinking");
   AST_STRAP: assert property (!$past(sys_rst) && $past(mode_strap) == 3'h4 |->
      light_mode == buck_fault_supervisor_pkg::LL_CONTINUOUS &&
      freq_sel == buck_fault_supervisor_pkg::FREQ_800K)
      else $error("strap decode wrong");
endmodule // buck_fault_supervisor_chk
bind buck_fault_supervisor buck_fault_supervisor_chk u_chk (.clk(clk), .sys_rst(sys_rst),
   .neg_limit_hit(neg_limit_hit), .mode_strap(mode_strap), .soft_start_run(soft_start_run),
   .ref_discharge(ref_discharge), .drive(drive), .neg_limit_active(neg_limit_active),
   .power_good_output(power_good_output), .undervoltage_trip(undervoltage_trip),
   .overvoltage_trip(overvoltage_trip), .output_sink_operation(output_sink_operation),
   .thermal_shutdown(thermal_shutdown), .light_mode(light_mode), .freq_sel(freq_sel));

// *** buck_fault_supervisor_far.sv ***
// far side model: switching pulses and negative current comparator
`timescale 1ns/10ps
module buck_fault_supervisor_far #(
   parameter int PERIOD = 4, // clocks per switching cycle
   parameter int RAMP = 6 // clocks of sinking until the limit trips
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire buck_fault_supervisor_pkg::drive_s drive,
   output logic switch_cycle,
   output logic neg_limit_hit
);
   int ph_q;
   int ramp_q;
   // one pulse a period; the timer keeps running while the low side sinks
   always_ff @(posedge clk) begin
      ph_q <= (sys_rst || ph_q == PERIOD - 1) ? 0 : ph_q + 1;
      switch_cycle <= !sys_rst && ph_q == 0;
   end
   // current ramps negative while low side is forced, fixed trip point
   always_ff @(posedge clk) begin
      ramp_q <= (sys_rst || !drive.low_side_force) ? 0 : ramp_q + 1;
      neg_limit_hit <= ramp_q == RAMP;
   end
endmodule // buck_fault_supervisor_far

// *** buck_fault_supervisor_tb_top.sv ***
// self-checking bench for the fault supervisor
`timescale 1ns/10ps
module buck_fault_supervisor_tb_top;
   localparam int UV = 10;
   localparam int PG = 8;
   logic clk = 0, sys_rst = 1, enable_in = 0, over_temp = 0, temp_recovered = 0;
   logic soft_start_done = 0, neg_limit_hit, switch_cycle, soft_start_run, ref_discharge;
   logic neg_limit_active, power_good_output, undervoltage_trip, overvoltage_trip;
   logic output_sink_operation, thermal_shutdown;
   logic [2:0] mode_strap = 3'h0;
   buck_fault_supervisor_pkg::feedback_sense_s fb = '0;
   buck_fault_supervisor_pkg::drive_s drive;
   buck_fault_supervisor_pkg::light_load_e light_mode;
   buck_fault_supervisor_pkg::freq_e freq_sel;
   int mismatches = 0, n_tests = 0, n;
   // rows: strap code, then expected {light mode, frequency}
   logic [5:0] rows [8] = '{6'h00, 6'h09, 6'h12, 6'h1c, 6'h25, 6'h2e, 6'h30, 6'h38};
   always #5 clk = ~clk;
   buck_fault_supervisor #(.UV_DELAY(UV), .PG_DELAY(PG)) DUT (.clk(clk), .sys_rst(sys_rst),
      .enable_in(enable_in), .feedback_sense(fb), .over_temp(over_temp),
      .temp_recovered(temp_recovered), .soft_start_done(soft_start_done),
      .neg_limit_hit(neg_limit_hit), .switch_cycle(switch_cycle), .mode_strap(mode_strap),
      .soft_start_run(soft_start_run), .ref_discharge(ref_discharge), .drive(drive),
      .neg_limit_active(neg_limit_active), .power_good_output(power_good_output),
      .undervoltage_trip(undervoltage_trip), .overvoltage_trip(overvoltage_trip),
      .output_sink_operation(output_sink_operation), .thermal_shutdown(thermal_shutdown),
      .light_mode(light_mode), .freq_sel(freq_sel));
   buck_fault_supervisor_far far (.clk(clk), .sys_rst(sys_rst), .drive(drive),
      .switch_cycle(switch_cycle), .neg_limit_hit(neg_limit_hit));
   // compare a packed group of flags
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // wait at falling edges until a flag reaches a level, n counts cycles
   task automatic wait_on(ref logic s, input logic lvl, input int lim);
      n = 0;
      while (s !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task give_verdict;
      if (mismatches == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      #100000;
      mismatches++;
      give_verdict;
   end
   initial begin
      cyc(2);
      sys_rst = 0;
      chk({ref_discharge, power_good_output, undervoltage_trip, overvoltage_trip}, 4'h8);
      for (int i = 0; i < 8; i++) begin
         mode_strap = rows[i][5:3];
         cyc(2);
         chk({light_mode, freq_sel}, {1'b0, rows[i][2:0]});
      end
      enable_in = 1;
      wait_on(soft_start_run, 1'b1, 10);
      fb.in_window = 1;
      fb.below_80 = 1;
      cyc(UV + PG);
      chk({soft_start_run, undervoltage_trip, power_good_output}, 4'h4);
      fb.below_80 = 0;
      soft_start_done = 1;
      wait_on(power_good_output, 1'b1, PG + 10);
      chk({power_good_output, n >= PG}, 4'h3);
      fb = 6'h10;
      cyc(UV - 4);
      fb = 6'h08;
      cyc(UV + 4);
      chk({undervoltage_trip, power_good_output}, 4'h0);
      fb = 6'h0e;
      wait_on(output_sink_operation, 1'b1, 10);
      chk({output_sink_operation, drive[2:1], neg_limit_active}, 4'hb);
      cyc(3);
      fb = 6'h08;
      cyc(4);
      chk({output_sink_operation, overvoltage_trip}, 4'h0);
      fb = 6'h0e;
      wait_on(output_sink_operation, 1'b1, 10);
      wait_on(output_sink_operation, 1'b0, 200);
      chk({output_sink_operation, n >= 14 * 4}, 4'h1);
      fb = 6'h01;
      wait_on(overvoltage_trip, 1'b1, 10);
      chk({overvoltage_trip, power_good_output, drive.high_side_en}, 4'h4);
      fb = 6'h20;
      cyc(4);
      enable_in = 0;
      cyc(3);
      chk(overvoltage_trip, 4'h0);
      fb = 6'h08;
      enable_in = 1;
      cyc(4);
      fb = 6'h10;
      wait_on(undervoltage_trip, 1'b1, UV + 10);
      chk({undervoltage_trip, drive.high_side_en, drive.low_side_force, n >= UV}, 4'h9);
      enable_in = 0;
      fb = 6'h08;
      cyc(2);
      enable_in = 1;
      cyc(4);
      over_temp = 1;
      soft_start_done = 0;
      wait_on(thermal_shutdown, 1'b1, 10);
      chk({thermal_shutdown, ref_discharge, drive.high_side_en}, 4'h6);
      over_temp = 0;
      temp_recovered = 1;
      wait_on(soft_start_run, 1'b1, 10);
      chk({soft_start_run, power_good_output}, 4'h2);
      sys_rst = 1;
      cyc(2);
      sys_rst = 0;
      chk({ref_discharge, soft_start_run, thermal_shutdown, power_good_output}, 4'h8);
      give_verdict;
   end
endmodule // buck_fault_supervisor_tb_top
